/* strap_decoder_defines.vh */
// constants for the mode-strap pin decoder
// Notes on behaviour
// - pin mode: edge pin high or low picks the data clock launch edge
// - pin mode: floating edge pin gives double-rate clock, edge choice ignored
// - pin mode: delay pin low gives short, high gives long calibration delay
// - pin mode: floating delay pin gives short delay and interleaved sampling
// - serial mode when primary low, or primary and full-scale float and secondary float/high
// - serial mode: swing, edge, delay pins become clock, data, chip select
// - primary pin high forces pin mode, serial port disabled
// - pin mode: full-scale pin low reduced range, high normal range
`ifndef STRAP_DECODER_DEFINES_VH
`define STRAP_DECODER_DEFINES_VH

// *********************************************
// three-level pin states
// *********************************************
`define TS_LOW 2'h0
`define TS_HIGH 2'h1
`define TS_FLOAT 2'h2

// *********************************************
// timing
// *********************************************
`define CLK_MHZ 40
`define STRAP_SETTLE_NS 1000
`define STRAP_SETTLE_CYC ((`STRAP_SETTLE_NS * `CLK_MHZ + 999) / 1000)

// *********************************************
// register map, byte addresses
// *********************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_STRAPS 4'h8

// control register fields
`define CTRL_RESCAN 0

// status register fields
`define ST_EXT_MODE 0
`define ST_BUSY 1
`define ST_EDGE_POS 2
`define ST_DDR 3
`define ST_CAL_LONG 4
`define ST_DES 5
`define ST_FULL_RANGE 6
`define ST_SWING_NORMAL 7

`endif

/* strap_sense.v */
// one three-level strap pin resolver
`timescale 1ns/1ps
`default_nettype none
`include "strap_decoder_defines.vh"

module strap_sense (
	input wire clk_i,
	input wire rst_i,
	input wire pin_i,
	input wire sample_up_i,
	input wire sample_dn_i,
	output reg [1:0] state_o
);

reg up_ff;

// *********************************************
// sample under pull-up, then resolve under pull-down
// *********************************************
always @(posedge clk_i) begin
	if (rst_i) begin
		up_ff <= 1'b0;
		state_o <= `TS_LOW;
	end else begin
		if (sample_up_i)
			up_ff <= pin_i;
		if (sample_dn_i) begin
			// follows both pulls: nobody drives the pin
			if (up_ff && !pin_i)
				state_o <= `TS_FLOAT;
			else if (pin_i)
				state_o <= `TS_HIGH;
			else
				state_o <= `TS_LOW;
		end
	end
end

endmodule // strap_sense
`default_nettype wire

/* control_mode_pin_decoder.v */
// mode-strap decoder with serial pin hand-over and wishbone status
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "strap_decoder_defines.vh"

module control_mode_pin_decoder #(
	parameter SETTLE_CYC = `STRAP_SETTLE_CYC
) (
	input wire clk_i,
	input wire rst_i,
	// wishbone classic slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	// strap pins
	input wire mode_primary_i,
	input wire mode_secondary_i,
	input wire full_scale_select_i,
	input wire output_swing_i,
	input wire output_edge_select_i,
	input wire calibration_delay_select_i,
	// weak bias used while probing the straps
	output reg strap_pull_o,
	output reg strap_pull_en_n_o,
	// settings from the serial register block
	input wire ser_edge_pos_i,
	input wire ser_ddr_i,
	input wire ser_cal_long_i,
	input wire ser_des_i,
	input wire ser_full_range_i,
	input wire ser_swing_normal_i,
	// decoded settings
	output reg ext_mode_o,
	output reg edge_pos_o,
	output reg ddr_o,
	output reg cal_long_o,
	output reg des_o,
	output reg full_range_normal_o,
	output reg swing_normal_o,
	// serial port pins, idle outside serial mode
	output reg serial_clock_o,
	output reg serial_data_in_o,
	output reg serial_chip_select_n_o
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_UP = 2'h1;
localparam [1:0] ST_DN = 2'h2;
localparam [1:0] ST_DECODE = 2'h3;
localparam [15:0] SETTLE_LAST = SETTLE_CYC - 1;

reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [15:0] cnt_ff;
reg [15:0] nxt_cnt;
reg ack_ff;
reg ext_ff;
reg rescan_ff;
wire [4:0] pins;
wire [9:0] ts;
wire sample_up;
wire sample_dn;
wire settled;
wire busy;
wire bus_req;
wire ext_now;
wire [1:0] pm_ts;
wire [1:0] sm_ts;
wire [1:0] fs_ts;
wire [1:0] edge_ts;
wire [1:0] cal_ts;

assign pins = {calibration_delay_select_i, output_edge_select_i,
	full_scale_select_i, mode_secondary_i, mode_primary_i};
assign pm_ts = ts[1:0];
assign sm_ts = ts[3:2];
assign fs_ts = ts[5:4];
assign edge_ts = ts[7:6];
assign cal_ts = ts[9:8];

// *********************************************
// strap probing sequence
// *********************************************
assign settled = (cnt_ff == SETTLE_LAST);
assign sample_up = (state_ff == ST_UP) && settled;
assign sample_dn = (state_ff == ST_DN) && settled;
assign busy = (state_ff != ST_IDLE);

always @* begin
	nxt_state = state_ff;
	nxt_cnt = 16'h0000;
	case (state_ff)
	ST_IDLE: begin
		if (rescan_ff)
			nxt_state = ST_UP;
	end
	ST_UP: begin
		nxt_cnt = cnt_ff + 16'h0001;
		if (settled) begin
			nxt_cnt = 16'h0000;
			nxt_state = ST_DN;
		end
	end
	ST_DN: begin
		nxt_cnt = cnt_ff + 16'h0001;
		if (settled) begin
			nxt_cnt = 16'h0000;
			nxt_state = ST_DECODE;
		end
	end
	ST_DECODE: nxt_state = ST_IDLE;
	default: nxt_state = ST_IDLE;
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		state_ff <= ST_UP;
		cnt_ff <= 16'h0000;
		strap_pull_o <= 1'b0;
		strap_pull_en_n_o <= 1'b1;
	end else begin
		state_ff <= nxt_state;
		cnt_ff <= nxt_cnt;
		strap_pull_o <= (nxt_state == ST_UP);
		strap_pull_en_n_o <= !(nxt_state == ST_UP || nxt_state == ST_DN);
	end
end

genvar g;
generate
	for (g = 0; g < 5; g = g + 1) begin : g_sense
		strap_sense u_sense (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.pin_i(pins[g]),
			.sample_up_i(sample_up),
			.sample_dn_i(sample_dn),
			.state_o(ts[2*g+1:2*g])
		);
	end
endgenerate

// *********************************************
// mode decision, latched once per scan
// *********************************************
// primary high never reaches the serial branch
assign ext_now = (pm_ts == `TS_LOW) ||
	((pm_ts == `TS_FLOAT) && (fs_ts == `TS_FLOAT) &&
	(sm_ts == `TS_FLOAT || sm_ts == `TS_HIGH));

always @(posedge clk_i) begin
	if (rst_i)
		ext_ff <= 1'b0;
	else if (state_ff == ST_DECODE)
		ext_ff <= ext_now;
end

// *********************************************
// settings outputs
// *********************************************
always @(posedge clk_i) begin
	if (rst_i) begin
		ext_mode_o <= 1'b0;
		edge_pos_o <= 1'b0;
		ddr_o <= 1'b0;
		cal_long_o <= 1'b0;
		des_o <= 1'b0;
		full_range_normal_o <= 1'b0;
		swing_normal_o <= 1'b0;
		serial_clock_o <= 1'b0;
		serial_data_in_o <= 1'b0;
		serial_chip_select_n_o <= 1'b1;
	end else if (ext_ff && !busy) begin
		ext_mode_o <= 1'b1;
		edge_pos_o <= ser_edge_pos_i;
		ddr_o <= ser_ddr_i;
		cal_long_o <= ser_cal_long_i;
		des_o <= ser_des_i;
		full_range_normal_o <= ser_full_range_i;
		swing_normal_o <= ser_swing_normal_i;
		serial_clock_o <= output_swing_i;
		serial_data_in_o <= output_edge_select_i;
		serial_chip_select_n_o <= calibration_delay_select_i;
	end else begin
		ext_mode_o <= 1'b0;
		// floating edge pin: double rate, edge choice irrelevant
		ddr_o <= (edge_ts == `TS_FLOAT);
		edge_pos_o <= (edge_ts == `TS_HIGH);
		cal_long_o <= (cal_ts == `TS_HIGH);
		des_o <= (cal_ts == `TS_FLOAT);
		full_range_normal_o <= (fs_ts == `TS_HIGH);
		swing_normal_o <= output_swing_i;
		serial_clock_o <= 1'b0;
		serial_data_in_o <= 1'b0;
		serial_chip_select_n_o <= 1'b1;
	end
end

// *********************************************
// wishbone slave
// *********************************************
assign bus_req = cyc_i && stb_i && !ack_ff;
assign ack_o = ack_ff;

always @(posedge clk_i) begin
	if (rst_i) begin
		ack_ff <= 1'b0;
		rescan_ff <= 1'b0;
		dat_o <= 32'h00000000;
	end else begin
		ack_ff <= bus_req;
		rescan_ff <= 1'b0;
		if (bus_req && we_i && adr_i == `REG_CTRL && sel_i[0])
			rescan_ff <= dat_i[`CTRL_RESCAN];
		if (bus_req && !we_i) begin
			case (adr_i)
			`REG_CTRL: dat_o <= 32'h00000000;
			`REG_STATUS: dat_o <= {24'h000000, swing_normal_o,
				full_range_normal_o, des_o, cal_long_o, ddr_o,
				edge_pos_o, busy, ext_mode_o};
			`REG_STRAPS: dat_o <= {22'h0, ts};
			default: dat_o <= 32'h00000000;
			endcase
		end
	end
end

endmodule // control_mode_pin_decoder
`default_nettype wire

/* dec_props.sv */
// concurrent checks on the strap decoder ports
`timescale 1ns/1ps
`default_nettype none
module dec_props (
	input wire clk_i,
	input wire rst_i,
	input wire output_swing_i,
	input wire output_edge_select_i,
	input wire calibration_delay_select_i,
	input wire ser_edge_pos_i,
	input wire ser_des_i,
	input wire strap_pull_o,
	input wire strap_pull_en_n_o,
	input wire ext_mode_o,
	input wire edge_pos_o,
	input wire cal_long_o,
	input wire des_o,
	input wire serial_clock_o,
	input wire serial_data_in_o,
	input wire serial_chip_select_n_o
);
	// ********
	// checks
	// ********
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence ext_held;
		ext_mode_o [*2];
	endsequence
	sequence probe_on;
		!strap_pull_en_n_o [*2];
	endsequence
	a_serial_idle: assert property (
		!ext_mode_o [*2] |-> !serial_clock_o && !serial_data_in_o
		&& serial_chip_select_n_o) else $error("serial pins not idle");
	a_clock_fwd: assert property (
		ext_held |-> serial_clock_o == $past(output_swing_i))
		else $error("serial clock not forwarded");
	a_data_fwd: assert property (
		ext_held |-> serial_data_in_o == $past(output_edge_select_i)
		&& serial_chip_select_n_o == $past(calibration_delay_select_i))
		else $error("serial data or select not forwarded");
	a_setting_fwd: assert property (
		ext_held |-> edge_pos_o == $past(ser_edge_pos_i)
		&& des_o == $past(ser_des_i)) else $error("serial settings lost");
	a_probe_up_first: assert property (
		$fell(strap_pull_en_n_o) |-> strap_pull_o)
		else $error("probe did not start pulled up");
	a_probe_order: assert property (
		$fell(strap_pull_o) |-> !strap_pull_en_n_o)
		else $error("pull-down phase without bias");
	a_des_short: assert property (
		!ext_mode_o && des_o |-> !cal_long_o)
		else $error("interleave with long delay");
	a_scan_pin_form: assert property (
		probe_on |-> !ext_mode_o && serial_chip_select_n_o)
		else $error("serial mode during probe");
endmodule // dec_props
bind control_mode_pin_decoder dec_props u_props (.*);
`default_nettype wire

/* strap_board.sv */
// board strap model: driven levels, or floating lines under the weak bias
`timescale 1ns/1ps
`default_nettype none
module strap_board (
	input wire clk_i,
	input wire pull_i,
	input wire pull_en_n_i,
	input wire [11:0] st_i,
	output logic [5:0] pin_o
);
	// ********
	// pin levels
	// ********
	logic tog_ff = 1'b0;
	always @(posedge clk_i)
		tog_ff <= ~tog_ff;
	// an unbiased float wanders instead of keeping its last level
	always_comb begin
		for (int i = 0; i < 6; i++)
			if (st_i[2*i+1])
				pin_o[i] = pull_en_n_i ? tog_ff : pull_i;
			else
				pin_o[i] = st_i[2*i];
	end
endmodule // strap_board
`default_nettype wire

/* tb.sv */
// random strap scans against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ********
	// bench
	// ********
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rd, dq;
	logic [11:0] st = 12'h0;
	logic [5:0] ser = 6'h0;
	logic [31:0] rng = 32'h00014b69;
	wire [5:0] pin;
	wire ack, pu, pen, ext, ep, dr, cl, ds, fr, sw, sc, sd, cs;
	int err_total = 0;
	int comparisons = 0;
	always #12.5 clk_i = ~clk_i;
	control_mode_pin_decoder #(.SETTLE_CYC(3)) DUT (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr),
		.sel_i(4'hf), .dat_i(wd), .dat_o(rd), .ack_o(ack),
		.mode_primary_i(pin[0]), .mode_secondary_i(pin[1]),
		.full_scale_select_i(pin[2]), .output_edge_select_i(pin[3]),
		.calibration_delay_select_i(pin[4]), .output_swing_i(pin[5]),
		.strap_pull_o(pu), .strap_pull_en_n_o(pen), .ser_edge_pos_i(ser[0]),
		.ser_ddr_i(ser[1]), .ser_cal_long_i(ser[2]), .ser_des_i(ser[3]),
		.ser_full_range_i(ser[4]), .ser_swing_normal_i(ser[5]),
		.ext_mode_o(ext), .edge_pos_o(ep), .ddr_o(dr), .cal_long_o(cl),
		.des_o(ds), .full_range_normal_o(fr), .swing_normal_o(sw),
		.serial_clock_o(sc), .serial_data_in_o(sd),
		.serial_chip_select_n_o(cs));
	strap_board B (.clk_i(clk_i), .pull_i(pu), .pull_en_n_i(pen),
		.st_i(st), .pin_o(pin));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tmo();
		err_total++;
		tally_and_finish();
	endtask
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 40);
		dq = rd;
		cyc <= 1'b0;
		if (n >= 40)
			tmo();
	endtask
	// polls the status word until the probe is over
	task automatic idle();
		int n;
		n = 0;
		do begin
			wb(1'b0, 4'h4, 32'h0);
			n++;
		end while (dq[1] !== 1'b0 && n < 40);
		if (n >= 40)
			tmo();
	endtask
	initial begin
		repeat (30000) @(posedge clk_i);
		tmo();
	end
	initial begin
		logic [31:0] r;
		logic [1:0] p, s, f, e, c;
		logic x;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, 4'hc, 32'hffffffff);
		for (int k = 0; k < 30; k++) begin
			r = xs();
			p = 2'(r % 3);
			s = 2'((r >> 4) % 3);
			f = 2'((r >> 8) % 3);
			e = 2'((r >> 12) % 3);
			c = 2'((r >> 16) % 3);
			x = p == 2'h0 || (p == 2'h2 && s != 2'h0 && f == 2'h2);
			if (!x && f == 2'h2)
				f = 2'h1;
			if (x) begin
				e[1] = 1'b0;
				c[1] = 1'b0;
			end
			idle();
			st <= {1'b0, r[20], c, e, f, s, p};
			wb(1'b1, 4'h0, 32'h1);
			idle();
			repeat (4) @(posedge clk_i);
			wb(1'b0, 4'h8, 32'h0);
			chk(dq, {c, e, f, s, p});
			wb(1'b0, 4'h4, 32'h0);
			chk(dq[1:0], {1'b0, x});
			chk(ext, x);
			if (!x) begin
				chk(dq[7:4], {r[20], f == 2'h1, c == 2'h2, c == 2'h1});
				if (e != 2'h2)
					chk(ep, e == 2'h1);
				chk(dr, e == 2'h2);
				chk(cl, c == 2'h1);
				chk(ds, c == 2'h2);
				chk(fr, f == 2'h1);
				chk(sw, r[20]);
				chk({sc, sd, cs}, 3'h1);
			end
			else
				for (int j = 0; j < 6; j++) begin
					@(posedge clk_i);
					r = xs();
					ser <= r[5:0];
					st[11:6] <= {1'b0, r[8], 1'b0, r[7], 1'b0, r[6]};
					@(posedge clk_i);
					#1;
					chk({sw, fr, ds, cl, dr, ep}, r[5:0]);
					chk({sc, sd, cs}, {r[8], r[6], r[7]});
				end
		end
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
